/* design/rcc_pkg.sv */
// Package for the reset cause capture block: addresses, bit positions, timing, carriers
package rcc_pkg;

   // Register addresses on the block's register port
   localparam logic [7:0] RCC_ADDR_CAUSE = 8'h00;
   localparam logic [7:0] RCC_ADDR_FORCE = 8'h01;

   // Bit positions in reset_cause_status
   localparam int RCC_BIT_POR = 7;
   localparam int RCC_BIT_PIN = 6;
   localparam int RCC_BIT_WDOG = 5;
   localparam int RCC_BIT_ILLEGAL_OPCODE_FLAG = 4;
   localparam int RCC_BIT_CLKGEN = 2;
   localparam int RCC_BIT_LVD = 1;

   // Bit position of force_reset_bit in debug_force_reset
   localparam int RCC_BIT_FORCE = 0;

   // Value of reset_cause_status after power-on, and the read value of the force register
   localparam logic [7:0] RCC_CAUSE_POR_VAL = 8'h82;
   localparam logic [7:0] RCC_FORCE_READ_VAL = 8'h00;
   localparam logic [7:0] RCC_ZERO_BYTE = 8'h00;

   // Minimum time the system reset is held, and its length in clock cycles
   localparam int RCC_CLK_PERIOD_PS = 25_000;
   localparam int RCC_HOLD_NS = 1000;
   localparam int RCC_HOLD_CYC_INT = (RCC_HOLD_NS * 1000 + RCC_CLK_PERIOD_PS - 1) / RCC_CLK_PERIOD_PS;
   localparam logic [5:0] RCC_HOLD_CYC = 6'(RCC_HOLD_CYC_INT);
   localparam logic [5:0] RCC_CNT_ZERO = 6'h00;

   // Controller states
   typedef enum logic [0:0] {
      RCC_ST_RUN = 1'b0,
      RCC_ST_HOLD = 1'b1
   } rcc_state_t;

   // Reset source levels and events from the rest of the chip
   typedef struct packed {
      logic pin_low;
      logic wdog_timeout;
      logic illegal_op;
      logic stop_exec;
      logic background_instruction_exec;
      logic clkgen_req;
      logic supply_low;
   } rcc_src_t;

   // Settings owned by the system option and debug control registers
   typedef struct packed {
      logic watchdog_enable_setting;
      logic stop_allow_setting;
      logic background_mode_allow;
      logic low_voltage_reset_enable;
      logic low_voltage_stop_enable;
   } rcc_cfg_t;

   // One register port access
   typedef struct packed {
      logic wr;
      logic rd;
      logic from_bdm;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcc_bus_t;

endpackage

/* design/rcc_reset_cause.sv */
// Reset cause capture: status flags, watchdog restart on write, debug forced reset
//
// Overview of operation
// - On every reset, flags of active sources are set, inactive ones cleared, except that low-voltage reset keeps bit 7.
// - A debug-forced reset sets no cause flag of its own; flags of other active sources are still set.
// - A write to the cause register outside a reset restarts the watchdog; flags stay unchanged.
// - Power-on sets power-on bit 7 and low-voltage bit 1, others cleared.
// - Low-voltage reset sets bit 1, keeps bit 7; other resets clear both.
// - External pin flag bit 6 set when the reset pin was held low.
// - Watchdog flag bit 5 on timeout; source blocked while watchdog disabled.
// - Illegal-opcode bit 4, including disallowed stop or background instruction.
// - Clock-generator flag bit 2 when the clock module requested reset.
// - Low-voltage reset only with both enables set and supply below trip.
// - Force-register writes from the user program are ignored.
// - Background write of 1 to force bit resets the chip; 0 does nothing.
// - Reads of the force register always return zero.

`timescale 1ns/100ps

module rcc_reset_cause (
   // Clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Reset sources and settings
   input wire rcc_pkg::rcc_src_t src_i,
   input wire rcc_pkg::rcc_cfg_t cfg_i,
   // Register port
   input wire rcc_pkg::rcc_bus_t bus_i,
   output logic [7:0] rd_data_o,
   // System side
   output logic sys_reset_o,
   output logic wdog_restart_o,
   output logic [7:0] cause_o
);
   import rcc_pkg::*;

   rcc_state_t state_ff;
   rcc_state_t nxt_state;
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic [7:0] flags_ff;
   logic [7:0] nxt_flags;
   logic [7:0] rd_data_ff;
   logic [7:0] nxt_rd_data;
   logic wdog_ff;
   logic nxt_wdog;

   logic [7:0] cause_now;
   logic lv_cause;
   logic illegal_opcode_flag_cause;
   logic force_req;
   logic user_force;
   logic cause_wr;
   logic any_cause;

   // Decode of the live reset sources into flag positions
   always_comb begin
      lv_cause = cfg_i.low_voltage_reset_enable && cfg_i.low_voltage_stop_enable
                 && src_i.supply_low;
      illegal_opcode_flag_cause = src_i.illegal_op
                   || (src_i.stop_exec && !cfg_i.stop_allow_setting)
                   || (src_i.background_instruction_exec && !cfg_i.background_mode_allow);
      cause_now = RCC_ZERO_BYTE;
      cause_now[RCC_BIT_POR] = lv_cause && flags_ff[RCC_BIT_POR];
      cause_now[RCC_BIT_PIN] = src_i.pin_low;
      cause_now[RCC_BIT_WDOG] = src_i.wdog_timeout && cfg_i.watchdog_enable_setting;
      cause_now[RCC_BIT_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_cause;
      cause_now[RCC_BIT_CLKGEN] = src_i.clkgen_req;
      cause_now[RCC_BIT_LVD] = lv_cause;
      any_cause = src_i.pin_low || cause_now[RCC_BIT_WDOG] || illegal_opcode_flag_cause
                  || src_i.clkgen_req || lv_cause;
   end

   // Register port decode; only background writes reach the force bit
   always_comb begin
      cause_wr = bus_i.wr && (bus_i.addr == RCC_ADDR_CAUSE);
      user_force = bus_i.wr && (bus_i.addr == RCC_ADDR_FORCE) && bus_i.from_bdm;
      force_req = user_force && bus_i.wdata[RCC_BIT_FORCE];
   end

   // Reset sequencer and flag capture
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_flags = flags_ff;
      nxt_wdog = 1'b0;
      nxt_rd_data = RCC_ZERO_BYTE;
      case (state_ff)
         RCC_ST_RUN: begin
            if (any_cause || force_req) begin
               // Forced reset contributes no flag of its own
               nxt_flags = cause_now;
               nxt_state = RCC_ST_HOLD;
               nxt_cnt = RCC_HOLD_CYC;
            end else begin
               // Flags are untouched by the restart write
               nxt_wdog = cause_wr;
               if (bus_i.rd && (bus_i.addr == RCC_ADDR_CAUSE)) begin
                  nxt_rd_data = flags_ff;
               end else if (bus_i.rd && (bus_i.addr == RCC_ADDR_FORCE)) begin
                  nxt_rd_data = RCC_FORCE_READ_VAL;
               end
            end
         end
         RCC_ST_HOLD: begin
            // Sources still active during the reset are gathered too
            nxt_flags = flags_ff | cause_now;
            if (cnt_ff != RCC_CNT_ZERO) begin
               nxt_cnt = cnt_ff - 6'h01;
            end else if (!any_cause) begin
               // A pin held low stretches the reset until released
               nxt_state = RCC_ST_RUN;
            end
         end
         default: begin
            nxt_state = RCC_ST_RUN;
         end
      endcase
   end

   // Power-on is the asynchronous reset, so it loads the power-on pattern
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= RCC_ST_RUN;
         cnt_ff <= RCC_CNT_ZERO;
         flags_ff <= RCC_CAUSE_POR_VAL;
         rd_data_ff <= RCC_ZERO_BYTE;
         wdog_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         flags_ff <= nxt_flags;
         rd_data_ff <= nxt_rd_data;
         wdog_ff <= nxt_wdog;
      end
   end

   // Outputs straight from flip-flops
   assign sys_reset_o = (state_ff == RCC_ST_HOLD);
   assign wdog_restart_o = wdog_ff;
   assign rd_data_o = rd_data_ff;
   assign cause_o = flags_ff;

   // Checks on the capture and register behaviour
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   logic [7:0] hold_len;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_len <= 8'h00;
      end else if (state_ff == RCC_ST_HOLD) begin
         hold_len <= hold_len + 8'h01;
      end else begin
         hold_len <= 8'h00;
      end
   end

   property p_latch;
      (state_ff == RCC_ST_RUN) && any_cause |=> sys_reset_o && (flags_ff == $past(cause_now));
   endproperty
   a_latch: assert property (p_latch) else $error("cause flags not latched on reset");

   property p_force_clear;
      (state_ff == RCC_ST_RUN) && force_req && !any_cause |=> sys_reset_o && (flags_ff == 8'h00);
   endproperty
   a_force_clear: assert property (p_force_clear) else $error("forced reset set a flag");

   property p_wdog;
      (state_ff == RCC_ST_RUN) && cause_wr && !any_cause && !force_req
         |=> wdog_restart_o && $stable(flags_ff) ##1 (!wdog_restart_o || $past(cause_wr));
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog restart missing");

   property p_lvd_keep_por;
      (state_ff == RCC_ST_RUN) && lv_cause
         |=> flags_ff[RCC_BIT_LVD] && (flags_ff[RCC_BIT_POR] == $past(flags_ff[RCC_BIT_POR]));
   endproperty
   a_lvd_keep_por: assert property (p_lvd_keep_por) else $error("low-voltage flags wrong");

   property p_other_clear_por;
      (state_ff == RCC_ST_RUN) && !lv_cause && (any_cause || force_req)
         |=> !flags_ff[RCC_BIT_POR] && !flags_ff[RCC_BIT_LVD];
   endproperty
   a_other_clear_por: assert property (p_other_clear_por) else $error("power flags kept");

   property p_pin;
      (state_ff == RCC_ST_RUN) && src_i.pin_low |=> flags_ff[RCC_BIT_PIN];
   endproperty
   a_pin: assert property (p_pin) else $error("pin flag not set");

   property p_wdog_block;
      (state_ff == RCC_ST_RUN) && !cfg_i.watchdog_enable_setting && !force_req
         && !src_i.pin_low && !illegal_opcode_flag_cause && !src_i.clkgen_req && !lv_cause
         |=> !sys_reset_o;
   endproperty
   a_wdog_block: assert property (p_wdog_block) else $error("blocked watchdog reset");

   property p_illegal_opcode_flag;
      (state_ff == RCC_ST_RUN) && src_i.stop_exec && !cfg_i.stop_allow_setting
         |=> flags_ff[RCC_BIT_ILLEGAL_OPCODE_FLAG];
   endproperty
   a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("illegal stop not flagged");

   property p_clkgen;
      (state_ff == RCC_ST_RUN) && src_i.clkgen_req |=> flags_ff[RCC_BIT_CLKGEN];
   endproperty
   a_clkgen: assert property (p_clkgen) else $error("clock generator flag not set");

   property p_lvd_gate;
      $rose(flags_ff[RCC_BIT_LVD])
         |-> $past(cfg_i.low_voltage_reset_enable) && $past(cfg_i.low_voltage_stop_enable)
             && $past(src_i.supply_low);
   endproperty
   a_lvd_gate: assert property (p_lvd_gate) else $error("low-voltage flag without cause");

   property p_user_force;
      (state_ff == RCC_ST_RUN) && bus_i.wr && !bus_i.from_bdm && !any_cause
         |=> !sys_reset_o;
   endproperty
   a_user_force: assert property (p_user_force) else $error("user write forced reset");

   property p_force_zero;
      (state_ff == RCC_ST_RUN) && user_force && !bus_i.wdata[RCC_BIT_FORCE] && !any_cause
         |=> !sys_reset_o;
   endproperty
   a_force_zero: assert property (p_force_zero) else $error("zero write forced reset");

   property p_force_hold;
      (state_ff == RCC_ST_RUN) && force_req |=> sys_reset_o [*8];
   endproperty
   a_force_hold: assert property (p_force_hold) else $error("forced reset too short");

   property p_force_read;
      (state_ff == RCC_ST_RUN) && bus_i.rd && (bus_i.addr == RCC_ADDR_FORCE)
         |=> (rd_data_o == 8'h00);
   endproperty
   a_force_read: assert property (p_force_read) else $error("force register read nonzero");

   property p_stable;
      (state_ff == RCC_ST_RUN) && !any_cause && !force_req |=> $stable(flags_ff)
         && !flags_ff[3] && !flags_ff[0];
   endproperty
   a_stable: assert property (p_stable) else $error("flags changed outside reset");

   property p_hold_min;
      $fell(sys_reset_o) |-> ($past(hold_len) >= 8'(RCC_HOLD_CYC_INT));
   endproperty
   a_hold_min: assert property (p_hold_min) else $error("reset released early");

   // Power-on pattern must stand at the first edge after release
   property p_por;
      $rose(rst_b_i) |-> (cause_o == RCC_CAUSE_POR_VAL) && !sys_reset_o
         && !wdog_restart_o && (rd_data_o == RCC_ZERO_BYTE);
   endproperty
   a_por: assert property (p_por) else $error("power-on pattern missing");

   // Enabled watchdog timeout is captured
   property p_wdog_flag;
      (state_ff == RCC_ST_RUN) && src_i.wdog_timeout && cfg_i.watchdog_enable_setting
         |=> sys_reset_o && flags_ff[RCC_BIT_WDOG];
   endproperty
   a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog flag not set");

   // Disallowed background instruction counts as illegal
   property p_background_instruction;
      (state_ff == RCC_ST_RUN) && src_i.background_instruction_exec && !cfg_i.background_mode_allow
         |=> flags_ff[RCC_BIT_ILLEGAL_OPCODE_FLAG];
   endproperty
   a_background_instruction: assert property (p_background_instruction) else $error("illegal background not flagged");

   // Status reads return the stored flags with the empty bits at zero
   property p_rd_cause;
      (state_ff == RCC_ST_RUN) && bus_i.rd && (bus_i.addr == RCC_ADDR_CAUSE) && !any_cause
         && !force_req |=> (rd_data_o == cause_o) && !rd_data_o[3] && !rd_data_o[0];
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("status read wrong");

   // Read data stands one cycle only, so idle cycles show zero
   property p_rd_idle;
      !bus_i.rd |=> (rd_data_o == RCC_ZERO_BYTE);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

   // Accesses are refused while the system reset is held
   property p_hold_refuse;
      sys_reset_o |=> !wdog_restart_o && (rd_data_o == RCC_ZERO_BYTE);
   endproperty
   a_hold_refuse: assert property (p_hold_refuse) else $error("access during reset");

   // The restart pulse comes only from a status write
   property p_wdog_only;
      !cause_wr |=> !wdog_restart_o;
   endproperty
   a_wdog_only: assert property (p_wdog_only) else $error("stray watchdog restart");

   // Main scenarios worth seeing at least once

   c_force: cover property ((state_ff == RCC_ST_RUN) && force_req ##1 sys_reset_o);
   c_pin: cover property ((state_ff == RCC_ST_RUN) && src_i.pin_low ##[1:100] $fell(sys_reset_o));
   c_wdog: cover property (wdog_restart_o);
   c_lvd: cover property ((state_ff == RCC_ST_RUN) && lv_cause ##1 flags_ff[RCC_BIT_LVD]);
   c_background_instruction: cover property ((state_ff == RCC_ST_RUN) && src_i.background_instruction_exec ##1 sys_reset_o);

endmodule

/* tb/rcc_dbg_host.sv */
// Debug host model: serial background single-byte writes into the block
`timescale 1ns/100ps
module rcc_dbg_host (
   // Clock
   input wire logic clk_i,
   // Bus toward the block
   output rcc_pkg::rcc_bus_t bus_o
);
   import rcc_pkg::*;
   initial bus_o = '0;
   // One background write; gap idles first to model a slow host
   task automatic write_byte(input logic [7:0] addr, input logic [7:0] data, input int gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      bus_o <= '{wr: 1'b1, rd: 1'b0, from_bdm: 1'b1, addr: addr, wdata: data};
      @(posedge clk_i);
      // Released lines do not keep their last value
      bus_o <= '{wr: 1'b0, rd: 1'b0, from_bdm: 1'b0, addr: ~addr, wdata: ~data};
   endtask
endmodule

/* tb/rcc_reset_cause_test.sv */
// Self-checking testbench for the reset cause capture block
`timescale 1ns/100ps
module rcc_reset_cause_test;
   import rcc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   rcc_src_t src = '0;
   rcc_cfg_t cfg = '0;
   rcc_bus_t tb_bus = '0;
   rcc_bus_t host_bus;
   rcc_bus_t bus;
   logic [7:0] rd_data;
   logic sys_reset;
   logic wdog_restart;
   logic [7:0] cause;
   int n_fail = 0;
   int n_compared = 0;
   // Clock at 40 MHz
   always #12.5 clk_i = ~clk_i;
   // Host owns the bus only while it strobes, so the two never collide
   assign bus = host_bus.wr ? host_bus : tb_bus;
   rcc_reset_cause u_rcc_reset_cause (.clk_i(clk_i), .rst_b_i(rst_b_i), .src_i(src),
      .cfg_i(cfg), .bus_i(bus), .rd_data_o(rd_data), .sys_reset_o(sys_reset),
      .wdog_restart_o(wdog_restart), .cause_o(cause));
   rcc_dbg_host u_rcc_dbg_host (.clk_i(clk_i), .bus_o(host_bus));
   // Verdict and end of run
   task automatic finish_test();
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Byte comparison, flags go in zero-extended
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One user access; answers are looked at just after the edge that takes it
   task automatic bus_op(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      tb_bus <= '{wr: wr, rd: rd, from_bdm: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      tb_bus <= '{wr: 1'b0, rd: 1'b0, from_bdm: 1'b0, addr: ~a, wdata: ~d};
      #1;
   endtask
   // Expected {reset taken, flags} for one source event; no reset keeps the flags
   function automatic logic [8:0] expect_of(rcc_src_t s, rcc_cfg_t c, logic [7:0] prev);
      logic [7:0] f;
      logic lv;
      lv = s.supply_low & c.low_voltage_reset_enable & c.low_voltage_stop_enable;
      f = 8'h00;
      f[RCC_BIT_PIN] = s.pin_low;
      f[RCC_BIT_WDOG] = s.wdog_timeout & c.watchdog_enable_setting;
      f[RCC_BIT_ILLEGAL_OPCODE_FLAG] = s.illegal_op | (s.stop_exec & ~c.stop_allow_setting) |
         (s.background_instruction_exec & ~c.background_mode_allow);
      f[RCC_BIT_CLKGEN] = s.clkgen_req;
      f[RCC_BIT_LVD] = lv;
      f[RCC_BIT_POR] = lv & prev[RCC_BIT_POR];
      return (|f) ? {1'b1, f} : {1'b0, prev};
   endfunction
   // One source event or host write, then ride out the reset with a bounded wait
   task automatic apply(input rcc_src_t s, input rcc_cfg_t c, input logic host,
         input logic [7:0] fw);
      logic [8:0] e;
      int hi;
      int k;
      e = expect_of(s, c, cause);
      if (host && fw[RCC_BIT_FORCE]) e = 9'h100;
      hi = 0;
      if (host) begin
         @(posedge clk_i);
         cfg <= c;
         u_rcc_dbg_host.write_byte(RCC_ADDR_FORCE, fw, $urandom_range(0, 3));
      end else begin
         @(posedge clk_i);
         cfg <= c;
         src <= s;
         @(posedge clk_i);
         src <= '0;
      end
      for (k = 0; k < 200; k++) begin
         #1;
         if (sys_reset === 1'b1) hi++;
         else if (hi > 0 || k > 5) break;
         @(posedge clk_i);
      end
      if (k == 200) begin
         n_fail++;
         $display("Error reset_release expected 0 seen %b", sys_reset);
         finish_test();
      end
      chk8("reset_cycles", 8'h01,
         {7'h00, (e[8] ? (hi == RCC_HOLD_CYC_INT + 1) : (hi == 0))});
      chk8("cause", e[7:0], cause);
      bus_op(1'b0, 1'b1, RCC_ADDR_CAUSE, 8'h00);
      chk8("cause_read", e[7:0], rd_data);
      bus_op(1'b1, 1'b0, RCC_ADDR_CAUSE, 8'($urandom()));
      chk8("wdog_restart", 8'h01, {7'h00, wdog_restart});
      chk8("cause_kept", e[7:0], cause);
      $display("Test done: src %h cfg %h host %b data %h", s, c, host, fw);
   endtask
   // Main sequence: power-on, register corners, every source both ways, then random
   initial begin
      int i;
      void'($urandom(32'h05f8));
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
      chk8("cause_por", RCC_CAUSE_POR_VAL, cause);
      apply(7'h01, 5'h03, 1'b0, 8'h00);
      bus_op(1'b1, 1'b0, RCC_ADDR_FORCE, 8'hff);
      bus_op(1'b0, 1'b1, RCC_ADDR_FORCE, 8'h00);
      chk8("force_read", RCC_FORCE_READ_VAL, rd_data);
      chk8("user_force", 8'h00, {7'h00, sys_reset});
      chk8("user_force_cause", 8'h82, cause);
      $display("Test done: register corners");
      apply(7'h00, 5'h1f, 1'b1, 8'hfe);
      apply(7'h00, 5'h1f, 1'b1, 8'h01);
      for (i = 0; i < 7; i++) begin
         apply(7'(1) << i, 5'h1f, 1'b0, 8'h00);
         apply(7'(1) << i, 5'h00, 1'b0, 8'h00);
      end
      for (i = 0; i < 12; i++) begin
         apply(7'(1) << $urandom_range(0, 6), 5'($urandom()), 1'b0, 8'h00);
      end
      apply(7'h00, 5'($urandom()), 1'b1, 8'h01);
      // Second power-on in mid-run must bring back the power-on pattern
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
      chk8("cause_por2", RCC_CAUSE_POR_VAL, cause);
      chk8("reset_idle", 8'h00, {7'h00, sys_reset});
      apply(7'h01, 5'h1f, 1'b0, 8'h00);
      finish_test();
   end
endmodule
